// *** logic/uhi_irq_ctrl.sv ***
// Interrupt status flags, enable mask and interrupt request of the USB host
`timescale 1ns/1ps
module uhi_irq_ctrl (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic cmdValid,
  input wire logic [7:0] cmdCode,
  input wire logic [31:0] cmdData,
  output logic rdValid,
  output logic [31:0] rdData,
  input wire uhi_pkg::uhi_evt_t events,
  output logic irqReq,
  output logic haltProcessing,
  output logic overrunTallyInc
);
  logic [31:0] enable_r;
  logic [31:0] rdData_r;
  logic rdValid_r;
  logic tallyInc_r;
  logic resSync1_r;
  logic resSync2_r;
  logic resPrev_r;
  logic frameMsbPrev_r;
  logic framePrimed_r;
  logic [uhi_pkg::FLAG_COUNT-1:0] setVec;
  logic [uhi_pkg::FLAG_COUNT-1:0] clrVec;
  logic [uhi_pkg::FLAG_COUNT-1:0] flags;
  logic [31:0] statusWord;
  logic enableWr;
  logic enableRd;
  logic statusWr;
  logic statusRd;
  logic resumeRise;
  logic frameWrap;

  // Command decode on the host port
  assign enableRd = cmdValid && (cmdCode == uhi_pkg::CMD_ENABLE_RD);
  assign enableWr = cmdValid && (cmdCode == uhi_pkg::CMD_ENABLE_WR);
  assign statusRd = cmdValid && (cmdCode == uhi_pkg::CMD_STATUS_RD);
  assign statusWr = cmdValid && (cmdCode == uhi_pkg::CMD_STATUS_WR);

  // Resume line comes from pins, so two flops before any edge logic
  // A line already high at reset release shows up as a fresh rise
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      resSync1_r <= 1'b0;
      resSync2_r <= 1'b0;
      resPrev_r <= 1'b0;
    end else begin
      resSync1_r <= events.resumeLine;
      resSync2_r <= resSync1_r;
      resPrev_r <= resSync2_r;
    end
  end

  // Edge only, and not when software drove the bus into resume
  assign resumeRise = resSync2_r && !resPrev_r && !events.swResume;

  // Frame counter MSB history; first sample only primes the compare
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      frameMsbPrev_r <= 1'b0;
      framePrimed_r <= 1'b0;
    end else begin
      frameMsbPrev_r <= events.frameMsb;
      framePrimed_r <= 1'b1;
    end
  end

  assign frameWrap = framePrimed_r && (events.frameMsb != frameMsbPrev_r);

  // Hardware set sources per flag position
  always_comb begin
    setVec = '0;
    setVec[uhi_pkg::BIT_ROOTHUB] = events.rootHubChange;
    setVec[uhi_pkg::BIT_WRAP] = frameWrap;
    // System errors are not reported by this part, flag stays low
    setVec[uhi_pkg::BIT_UNRECOV] = 1'b0;
    setVec[uhi_pkg::BIT_RESUME] = resumeRise;
    setVec[uhi_pkg::BIT_SOF] = events.sofStart;
    setVec[uhi_pkg::BIT_OVERRUN] = events.schedOverrun;
  end

  // Write-one-to-clear on the status register
  // Bit 4 has no cell, so a one written there lands nowhere
  assign clrVec = statusWr ? cmdData[uhi_pkg::FLAG_COUNT-1:0] : '0;

  // One sticky cell per implemented bit except bit 4; reserved positions and bit 4 tie low
  for (genvar i = 0; i < uhi_pkg::FLAG_COUNT; i++) begin : gFlag
    if (uhi_pkg::STATUS_MASK[i] && (i != uhi_pkg::BIT_UNRECOV)) begin : gCell
      uhi_sticky_flag uFlag (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .setPulse(setVec[i]),
        .clrPulse(clrVec[i]),
        .flag(flags[i])
      );
    end else begin : gZero
      assign flags[i] = 1'b0;
    end
  end

  assign statusWord = {{(32 - uhi_pkg::FLAG_COUNT){1'b0}}, flags} & uhi_pkg::STATUS_MASK;

  // Enable register: write-one-to-set, no way to clear it from here
  // No disable register or command exists in this block; reset is the only clear
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      enable_r <= uhi_pkg::ENABLE_RESET;
    end else if (enableWr) begin
      enable_r <= enable_r | (cmdData & uhi_pkg::ENABLE_MASK);
    end
  end

  // Read answer one cycle after the command
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rdData_r <= uhi_pkg::RDATA_RESET;
      rdValid_r <= 1'b0;
    end else begin
      rdValid_r <= enableRd || statusRd;
      if (enableRd) begin
        rdData_r <= enable_r;
      end else if (statusRd) begin
        rdData_r <= statusWord;
      end
    end
  end

  // Overrun tally lives elsewhere; pass it a registered bump
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      tallyInc_r <= 1'b0;
    end else begin
      tallyInc_r <= events.schedOverrun;
    end
  end

  // Request is combinational so it drops the cycle the cause goes
  assign irqReq = enable_r[uhi_pkg::BIT_MASTER] &&
                  (|(flags & enable_r[uhi_pkg::FLAG_COUNT-1:0]));
  assign haltProcessing = flags[uhi_pkg::BIT_UNRECOV];
  assign rdValid = rdValid_r;
  assign rdData = rdData_r;
  assign overrunTallyInc = tallyInc_r;

  // Checks sleep through reset and all run on the one system clock
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  // Event flags: each event except system error and software resume sets its flag, and nothing else does
  roothub_set_a: assert property (events.rootHubChange |=> flags[uhi_pkg::BIT_ROOTHUB])
    else $error("root hub change did not set flag");
  roothub_quiet_a: assert property (
    !flags[uhi_pkg::BIT_ROOTHUB] && !events.rootHubChange |=> !flags[uhi_pkg::BIT_ROOTHUB])
    else $error("root hub flag set with no change");
  wrap_set_a: assert property (framePrimed_r && $changed(events.frameMsb) |=> flags[uhi_pkg::BIT_WRAP])
    else $error("frame counter wrap did not set flag");
  wrap_quiet_a: assert property (
    !flags[uhi_pkg::BIT_WRAP] && $stable(events.frameMsb) |=> !flags[uhi_pkg::BIT_WRAP])
    else $error("frame wrap flag set with steady counter");
  unrecov_low_a: assert property (!flags[uhi_pkg::BIT_UNRECOV] && !haltProcessing)
    else $error("unrecoverable error flag not low");
  syserr_ignored_a: assert property (
    events.sysError |=> !flags[uhi_pkg::BIT_UNRECOV] && !haltProcessing)
    else $error("system error reached the flag");
  resume_set_a: assert property ($rose(resSync2_r) && !events.swResume |=> flags[uhi_pkg::BIT_RESUME])
    else $error("resume edge did not set flag");
  resume_quiet_a: assert property (
    !flags[uhi_pkg::BIT_RESUME] && !$rose(resSync2_r) |=> !flags[uhi_pkg::BIT_RESUME])
    else $error("resume flag set with no rise");
  resume_sw_a: assert property (
    !flags[uhi_pkg::BIT_RESUME] && events.swResume ##1 1'b1 |-> !flags[uhi_pkg::BIT_RESUME])
    else $error("software resume set the flag");
  sof_set_a: assert property (events.sofStart |=> flags[uhi_pkg::BIT_SOF])
    else $error("frame start did not set flag");
  sof_quiet_a: assert property (
    !flags[uhi_pkg::BIT_SOF] && !events.sofStart |=> !flags[uhi_pkg::BIT_SOF])
    else $error("frame start flag set with no frame");
  overrun_set_a: assert property (events.schedOverrun |=> flags[uhi_pkg::BIT_OVERRUN] && overrunTallyInc)
    else $error("overrun flag or tally bump missing");
  overrun_quiet_a: assert property (
    !flags[uhi_pkg::BIT_OVERRUN] && !events.schedOverrun |=> !flags[uhi_pkg::BIT_OVERRUN])
    else $error("overrun flag set with no overrun");
  tally_quiet_a: assert property (!events.schedOverrun |=> !overrunTallyInc)
    else $error("tally bumped with no overrun");
  flag_hold_a: assert property (
    flags[uhi_pkg::BIT_SOF] && !(statusWr && cmdData[uhi_pkg::BIT_SOF]) |=> flags[uhi_pkg::BIT_SOF])
    else $error("status flag lost without clear");
  status_clear_a: assert property (
    statusWr && cmdData[uhi_pkg::BIT_SOF] && !events.sofStart |=> !flags[uhi_pkg::BIT_SOF])
    else $error("status flag not cleared by write");

  // Interrupt gate follows flags, enables and master at once
  irq_gate_a: assert property (irqReq |-> enable_r[uhi_pkg::BIT_MASTER] && (statusWord & enable_r) != 32'h0)
    else $error("interrupt without enabled flag and master");
  irq_on_a: assert property (
    enable_r[uhi_pkg::BIT_MASTER] && (statusWord & enable_r) != 32'h0 |-> irqReq)
    else $error("interrupt missing with enabled flag");
  irq_drop_a: assert property (
    !enable_r[uhi_pkg::BIT_MASTER] || (statusWord & enable_r) == 32'h0 |-> !irqReq)
    else $error("interrupt held with no cause");

  // Host port commands and answers
  enable_w1s_a: assert property (
    enableWr |=> enable_r == ($past(enable_r) | ($past(cmdData) & uhi_pkg::ENABLE_MASK)))
    else $error("enable write not set-only");
  enable_keep_a: assert property (!enableWr |=> enable_r == $past(enable_r))
    else $error("enable changed without a write");
  enable_read_a: assert property (
    enableRd |=> rdValid && rdData == $past(enable_r) && enable_r == $past(enable_r))
    else $error("enable read wrong or had side effect");
  status_read_a: assert property (statusRd |=> rdValid && rdData == $past(statusWord))
    else $error("status read wrong");
  no_answer_a: assert property (!enableRd && !statusRd |=> !rdValid)
    else $error("answer without a read command");
  reserved_zero_a: assert property (
    (statusWord & ~uhi_pkg::STATUS_MASK) == 32'h0 && enable_r[30:7] == 24'h0)
    else $error("reserved bit not zero");
endmodule : uhi_irq_ctrl

// *** logic/uhi_pkg.sv ***
// Package: constants and event carrier for the host interrupt status/enable block
package uhi_pkg;

  // Host port command codes
  localparam logic [7:0] CMD_ENABLE_RD = 8'h04;
  localparam logic [7:0] CMD_ENABLE_WR = 8'h84;
  localparam logic [7:0] CMD_STATUS_RD = 8'h03;
  localparam logic [7:0] CMD_STATUS_WR = 8'h83;

  // Flag positions, shared by status and enable; BIT_MASTER (bit 31) is in the enable register only
  localparam int BIT_OVERRUN = 0;
  localparam int BIT_SOF = 2;
  localparam int BIT_RESUME = 3;
  localparam int BIT_UNRECOV = 4;
  localparam int BIT_WRAP = 5;
  localparam int BIT_ROOTHUB = 6;
  localparam int BIT_MASTER = 31;
  localparam int FLAG_COUNT = 7;

  // Implemented bits; everything else reads zero
  localparam logic [31:0] STATUS_MASK = 32'h0000007d;
  localparam logic [31:0] ENABLE_MASK = 32'h8000007d;

  // Values after reset
  localparam logic [31:0] ENABLE_RESET = 32'h00000000;
  localparam logic [31:0] RDATA_RESET = 32'h00000000;

  // Event sources from the frame counter, root hub, scheduler and bus
  typedef struct packed {
    logic rootHubChange; // Pulse: hub or port status content changed
    logic frameMsb;      // Level: bit 15 of the frame counter
    logic sysError;      // Pulse: system error not related to USB
    logic resumeLine;    // Level from the bus pins, asynchronous
    logic swResume;      // Level: software put the bus in resume state
    logic sofStart;      // Pulse: frame start, SOF token issued
    logic schedOverrun;  // Pulse: schedule overran this frame
  } uhi_evt_t;

endpackage : uhi_pkg

// *** logic/uhi_sticky_flag.sv ***
// Sticky event flag cell, hardware set wins over software clear
`timescale 1ns/1ps
module uhi_sticky_flag (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic setPulse,
  input wire logic clrPulse,
  output logic flag
);
  logic flag_r;

  // Set beats clear so an event in the clearing cycle is kept
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      flag_r <= 1'b0;
    end else if (setPulse) begin
      flag_r <= 1'b1;
    end else if (clrPulse) begin
      flag_r <= 1'b0;
    end
  end

  assign flag = flag_r;
endmodule : uhi_sticky_flag

// *** sim/uhi_host_model.sv ***
// Host processor model: issues port commands and collects read answers
`timescale 1ns/1ps
module uhi_host_model (
  input wire logic clk_sys,
  output logic cmdValid,
  output logic [7:0] cmdCode,
  output logic [31:0] cmdData,
  input wire logic rdValid,
  input wire logic [31:0] rdData
);
  // Bus idle before the first command
  initial begin
    cmdValid = 1'b0;
    cmdCode = 8'h00;
    cmdData = 32'h00000000;
  end
  // One strobe per command, dropped at the edge that takes it
  task automatic issue(input logic [7:0] code, input logic [31:0] data);
    @(posedge clk_sys);
    cmdValid <= 1'b1;
    cmdCode <= code;
    cmdData <= data;
    @(posedge clk_sys);
    cmdValid <= 1'b0;
    cmdData <= ~data; // Stale data must not matter once released
  endtask : issue
  // Answer stands only in the cycle after the taking edge
  task automatic fetch(input logic [7:0] code, output logic [31:0] value, output logic got);
    issue(code, 32'h00000000);
    #1;
    got = rdValid;
    value = rdData;
  endtask : fetch
endmodule : uhi_host_model

// *** sim/usb_host_irq_status_enable_tb.sv ***
// Self-checking bench for the interrupt status and enable block
`timescale 1ns/1ps
module usb_host_irq_status_enable_tb;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic cmdValid, rdValid, irqReq, haltProcessing, overrunTallyInc, got;
  logic [7:0] cmdCode;
  logic [31:0] cmdData, rdData, value;
  uhi_pkg::uhi_evt_t events = '0;
  int miscompares = 0;
  int tests_run = 0;
  int tally = 0;
  // Event table: mask, pulse or level, expected status
  logic [6:0] evMask [10] = '{7'h40, 7'h20, 7'h20, 7'h10, 7'h04, 7'h08, 7'h0c, 7'h08, 7'h02, 7'h01};
  logic evPulse [10] = '{1'h1, 1'h0, 1'h0, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1, 1'h1};
  logic [31:0] evExp [10] = '{32'h40, 32'h20, 32'h20, 32'h0, 32'h0, 32'h0, 32'h0, 32'h08, 32'h04, 32'h01};
  // Clock generator
  always #25 clk_sys = ~clk_sys;
  // Counts tally pulses, so a stretched pulse shows up
  always @(posedge clk_sys) if (overrunTallyInc === 1'b1) tally++;
  uhi_irq_ctrl uhi_irq_ctrl_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .cmdValid(cmdValid), .cmdCode(cmdCode),
    .cmdData(cmdData), .rdValid(rdValid), .rdData(rdData), .events(events), .irqReq(irqReq),
    .haltProcessing(haltProcessing), .overrunTallyInc(overrunTallyInc));
  uhi_host_model uhi_host_model_i (.clk_sys(clk_sys), .cmdValid(cmdValid), .cmdCode(cmdCode),
    .cmdData(cmdData), .rdValid(rdValid), .rdData(rdData));
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : report_and_stop
  task automatic check(input logic [31:0] gotV, input logic [31:0] expV, input string what);
    tests_run++;
    if (gotV !== expV) begin
      miscompares++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, gotV, expV);
    end
  endtask : check
  // A read with no answer ends the run
  task automatic read_reg(input logic [7:0] code, input logic [31:0] expV, input string what);
    uhi_host_model_i.fetch(code, value, got);
    check({31'h0, got}, 32'h1, "read answer");
    if (got !== 1'b1) report_and_stop();
    check(value, expV, what);
  endtask : read_reg
  // Pulses drop after one cycle; the wait covers the resume synchroniser
  task automatic fire(input logic [6:0] m, input logic pulse);
    @(posedge clk_sys);
    events <= events ^ uhi_pkg::uhi_evt_t'(m);
    if (pulse) begin
      @(posedge clk_sys);
      events <= events ^ uhi_pkg::uhi_evt_t'(m);
    end
    repeat (4) @(posedge clk_sys);
  endtask : fire
  // Main sequence
  initial begin
    repeat (8) @(posedge clk_sys);
    sys_rst <= 1'b0;
    read_reg(uhi_pkg::CMD_ENABLE_RD, 32'h00000000, "enable reset");
    read_reg(uhi_pkg::CMD_STATUS_RD, 32'h00000000, "status reset");
    $display("reset test done");
    for (int i = 0; i < 10; i++) begin
      fire(evMask[i], evPulse[i]);
      read_reg(uhi_pkg::CMD_STATUS_RD, evExp[i], "flag set");
      read_reg(uhi_pkg::CMD_STATUS_RD, evExp[i], "flag sticky");
      check({31'h0, irqReq}, 32'h0, "request while disabled");
      check({31'h0, haltProcessing}, 32'h0, "halt");
      uhi_host_model_i.issue(uhi_pkg::CMD_STATUS_WR, 32'hffffffef);
      read_reg(uhi_pkg::CMD_STATUS_RD, 32'h00000000, "flag cleared");
    end
    check(tally, 32'h1, "overrun tally pulses");
    $display("event test done");
    uhi_host_model_i.issue(uhi_pkg::CMD_ENABLE_WR, 32'h00000004);
    fire(7'h02, 1'b1);
    read_reg(uhi_pkg::CMD_ENABLE_RD, 32'h00000004, "enable set");
    check({31'h0, irqReq}, 32'h0, "no master gate");
    uhi_host_model_i.issue(uhi_pkg::CMD_ENABLE_WR, 32'h80000000);
    read_reg(uhi_pkg::CMD_ENABLE_RD, 32'h80000004, "master set");
    check({31'h0, irqReq}, 32'h1, "request raised");
    uhi_host_model_i.issue(uhi_pkg::CMD_ENABLE_WR, 32'h00000000);
    fire(7'h01, 1'b1);
    read_reg(uhi_pkg::CMD_ENABLE_RD, 32'h80000004, "zeros keep");
    read_reg(uhi_pkg::CMD_STATUS_RD, 32'h00000005, "two flags");
    uhi_host_model_i.issue(uhi_pkg::CMD_STATUS_WR, 32'h00000004);
    read_reg(uhi_pkg::CMD_STATUS_RD, 32'h00000001, "one cleared");
    check({31'h0, irqReq}, 32'h0, "request dropped");
    uhi_host_model_i.issue(uhi_pkg::CMD_ENABLE_WR, 32'hffffffff);
    read_reg(uhi_pkg::CMD_ENABLE_RD, 32'h8000007d, "enable all");
    check({31'h0, irqReq}, 32'h1, "overrun enabled");
    uhi_host_model_i.fetch(8'h05, value, got);
    check({31'h0, got}, 32'h0, "unknown code answered");
    $display("enable test done");
    // Second reset in mid-run, resume line idle first; only reset clears the enables
    fire(7'h08, 1'b0);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    read_reg(uhi_pkg::CMD_ENABLE_RD, 32'h00000000, "enable after reset");
    read_reg(uhi_pkg::CMD_STATUS_RD, 32'h00000000, "status after reset");
    check({31'h0, irqReq}, 32'h0, "request after reset");
    $display("second reset test done");
    report_and_stop();
  end
endmodule : usb_host_irq_status_enable_tb
